/* sim/conv_core_model.sv */
module conv_core_model (
    // Converter control
    input wire logic conv_enable,
    // Value the analog side would settle to
    input wire logic [11:0] value,
    // Result towards the registers
    output logic [11:0] conv_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // A powered-down core shows the inverse, so a stale capture cannot match
    assign conv_data = conv_enable ? value : ~value;
endmodule

/* sim/tb_adc_control_registers.sv */
module tb_adc_control_registers;
    import adc_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_seen;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, conv_channel;
    logic [11:0] conv_data, value;
    logic conv_enable, conv_sample, conv_clk_en, conv_bandgap, conv_busy;
    logic [3:0] chans [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hF,
        4'h7, 4'hC};
    int errors, cmp_count, samples, ticks, gap, exp_gap;

    adc_control_registers DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_data(conv_data), .conv_enable(conv_enable),
        .conv_sample(conv_sample), .conv_clk_en(conv_clk_en), .conv_channel(conv_channel),
        .conv_bandgap(conv_bandgap), .conv_busy(conv_busy));
    conv_core_model core (.conv_enable(conv_enable), .value(value), .conv_data(conv_data));

    // Free-running system clock
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; starts on a fresh edge so release and next setup never collide
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            chk("pready", 32'h1, 32'h0);
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] ctrl_val(logic en, logic flag, logic [3:0] ch);
        return {24'h0, en, flag, ch, 2'b00};
    endfunction

    // Pin codes pass through; reserved codes and the reference give no pin
    function automatic logic [3:0] pin_of(logic [3:0] ch);
        return (ch <= 4'h6 || ch == 4'h8 || ch == 4'h9) ? ch : 4'h0;
    endfunction

    task automatic tally_and_finish;
        $display("Comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Converter tick spacing and count per conversion
    always @(posedge pclk)
    begin
        if (conv_sample === 1'b1)
        begin
            samples++;
            ticks = 0;
            gap = 0;
        end
        else
        begin
            gap++;
            if (conv_clk_en === 1'b1)
            begin
                if (ticks > 0)
                    chk("tick gap", exp_gap, gap);
                ticks++;
                gap = 0;
            end
        end
    end

    // Hang guard, well beyond the slowest divider sweep
    initial
    begin
        #200000;
        errors++;
        tally_and_finish;
    end

    initial
    begin
        logic [11:0] v;
        logic [3:0] ch;
        int div, n;
        {presetn, psel, penable, pwrite, paddr, pwdata, value} = '0;
        pstrb = 4'hF;
        exp_gap = 1;
        v = 12'($urandom(9));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b1, CTRL_ADDR, 32'h40);
        repeat (40) @(posedge pclk);
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk("ctrl start while off", 32'h0, rd);
        chk("sample pulses", 32'h0, samples);
        apb(1'b0, 8'h90, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err_seen});
        // A write without byte lane zero must leave the control word alone
        pstrb <= 4'hE;
        apb(1'b1, CTRL_ADDR, 32'h80);
        pstrb <= 4'hF;
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk("ctrl lane off", 32'h0, rd);
        // Sweep every divider code and twelve of the channel codes with random results
        for (int i = 0; i < 12; i++)
        begin
            v = 12'($urandom);
            ch = chans[i];
            div = i % 8;
            exp_gap = 1 << div;
            value <= v;
            apb(1'b1, MODE_ADDR, {24'h0, RES_12BIT, 1'b0, div[2:0], 1'b0});
            apb(1'b0, MODE_ADDR, 32'h0);
            chk("mode read", 32'h0, rd);
            chk("mode error", 32'h0, {31'h0, err_seen});
            apb(1'b1, CTRL_ADDR, ctrl_val(1'b1, 1'b1, ch));
            apb(1'b0, CTRL_ADDR, 32'h0);
            chk("ctrl busy", ctrl_val(1'b1, 1'b0, ch), rd);
            chk("pin", {28'h0, pin_of(ch)}, {28'h0, conv_channel});
            chk("reference", {31'h0, ch == 4'hF}, {31'h0, conv_bandgap});
            chk("busy", 32'h1, {31'h0, conv_busy});
            n = 0;
            do
            begin
                apb(1'b0, CTRL_ADDR, 32'h0);
                n++;
            end
            while (rd[6] !== 1'b1 && n < 1000);
            chk("ctrl done", ctrl_val(1'b1, 1'b1, ch), rd);
            chk("idle busy", 32'h0, {31'h0, conv_busy});
            chk("sample pulses", i + 1, samples);
            chk("tick count", 32'(CONV_TICKS), ticks);
            value <= ~v;
            apb(1'b1, RESH_ADDR, 32'hFF);
            apb(1'b0, RESH_ADDR, 32'h0);
            chk("result high", {24'h0, v[11:4]}, rd);
            chk("result top bit", {31'h0, v[11]}, {31'h0, rd[7]});
            apb(1'b0, RESL_ADDR, 32'h0);
            chk("result low", {24'h0, v[3:0], 4'h0}, rd);
        end
        apb(1'b1, CTRL_ADDR, 32'h0);
        repeat (2) @(posedge pclk);
        chk("enable off", 32'h0, {31'h0, conv_enable});
        tally_and_finish;
    end
endmodule

/* verilog/adc_control_registers.sv */
// Added by the designer: the APB slave port.
module adc_control_registers
    import adc_ctrl_pkg::*;
(
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Conversion core
    input wire logic [11:0] conv_data,
    output logic conv_enable,
    output logic conv_sample,
    output logic conv_clk_en,
    output logic [3:0] conv_channel,
    output logic conv_bandgap,
    output logic conv_busy
);

    typedef enum logic [1:0] {IDLE, CONVERT, DONE_ST} conv_state_t;

    logic enable_q;
    logic done_q;
    logic start_q;
    logic [3:0] chan_q;
    logic [2:0] res_q;
    logic [2:0] div_q;
    logic [6:0] divcnt_q;
    logic tick_q;
    logic [4:0] ticks_q;
    logic [11:0] result_q;
    conv_state_t state_q;
    logic wr_en;
    logic rd_en;
    logic mapped;

    // True for the four register words; anything else answers with an error
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == CTRL_ADDR) || (a == MODE_ADDR) || (a == RESH_ADDR)
            || (a == RESL_ADDR);
    endfunction

    // Terminal count of the divider: 2**code - 1
    function automatic logic [6:0] div_limit(input logic [2:0] code);
        div_limit = 7'((8'h01 << code) - 8'h01);
    endfunction

    // Access phase is single cycle, so pready is high in every access phase
    assign wr_en = psel && penable && pwrite && pstrb[0];
    assign rd_en = psel && penable && !pwrite;
    assign mapped = addr_mapped(paddr);

    // Enable bit and channel field
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_q <= 1'b0;
            chan_q <= CHAN_RESET;
        end
        else if (wr_en && paddr == CTRL_ADDR)
        begin
            enable_q <= pwdata[ENABLE_BIT];
            chan_q <= pwdata[CHAN_LSB +: 4];
        end
    end

    // Mode register fields; reserved bit 4 and bit 0 are not stored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            res_q <= RES_RESET;
            div_q <= DIV_RESET;
        end
        else if (wr_en && paddr == MODE_ADDR)
        begin
            res_q <= pwdata[RES_LSB +: 3];
            div_q <= pwdata[DIV_LSB +: 3];
        end
    end

    // Pending start request; enable set in the same write counts, otherwise it is dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            start_q <= 1'b0;
        else if (wr_en && paddr == CTRL_ADDR && pwdata[START_BIT] && pwdata[ENABLE_BIT])
            start_q <= 1'b1;
        else if (!enable_q)
            start_q <= 1'b0;
        else if (state_q == IDLE || state_q == DONE_ST)
            start_q <= 1'b0;
    end

    // Converter clock divider, run only while enabled to save toggling
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            divcnt_q <= 7'h00;
            tick_q <= 1'b0;
        end
        else if (!enable_q)
        begin
            divcnt_q <= 7'h00;
            tick_q <= 1'b0;
        end
        else if (divcnt_q >= div_limit(div_q))
        begin
            divcnt_q <= 7'h00;
            tick_q <= 1'b1;
        end
        else
        begin
            divcnt_q <= divcnt_q + 7'h01;
            tick_q <= 1'b0;
        end
    end

    // Conversion sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= IDLE;
            ticks_q <= 5'h00;
        end
        else if (!enable_q)
            state_q <= IDLE;
        else
        begin
            case (state_q)
                IDLE, DONE_ST:
                    if (start_q)
                    begin
                        state_q <= CONVERT;
                        ticks_q <= 5'h00;
                    end
                CONVERT:
                    if (tick_q)
                    begin
                        if (ticks_q == CONV_TICKS - 5'h01)
                            state_q <= DONE_ST;
                        ticks_q <= ticks_q + 5'h01;
                    end
                default:
                    state_q <= IDLE;
            endcase
        end
    end

    // Process flag: clears as conversion begins, sets on completion only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            done_q <= 1'b0;
        else if (!enable_q)
            done_q <= 1'b0;
        else if (state_q == CONVERT && tick_q && ticks_q == CONV_TICKS - 5'h01)
            done_q <= 1'b1;
        else if ((state_q == IDLE || state_q == DONE_ST) && start_q)
            done_q <= 1'b0;
    end

    // Result captured only at completion and held until the next one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            result_q <= 12'h000;
        else if (enable_q && state_q == CONVERT && tick_q && ticks_q == CONV_TICKS - 5'h01)
            result_q <= conv_data;
    end

    // Drive the conversion core from registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            conv_enable <= 1'b0;
            conv_sample <= 1'b0;
            conv_clk_en <= 1'b0;
            conv_channel <= CHAN_RESET;
            conv_bandgap <= 1'b0;
            conv_busy <= 1'b0;
        end
        else
        begin
            conv_enable <= enable_q;
            conv_sample <= enable_q && (state_q != CONVERT) && start_q;
            conv_clk_en <= tick_q && state_q == CONVERT;
            // Reserved codes route nothing; band-gap replaces any pin
            conv_channel <= (chan_q <= CHAN_MAX_PIN && chan_q != CHAN_RSVD) ? chan_q
                : CHAN_RESET;
            conv_bandgap <= (chan_q == CHAN_BANDGAP);
            conv_busy <= state_q == CONVERT;
        end
    end

    // APB read data and response
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    CTRL_ADDR:
                        prdata <= {24'h000000, enable_q, done_q, chan_q, 2'b00};
                    RESH_ADDR:
                        prdata <= {24'h000000, result_q[11:4]};
                    RESL_ADDR:
                        prdata <= {24'h000000, result_q[3:0], 4'h0};
                    default:
                        prdata <= 32'h0000_0000; // Mode register is write-only
                endcase
            end
        end
    end

    // Start on an enabled write leads to the convert state within one to three clock cycles
    start_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == CTRL_ADDR && pwdata[ENABLE_BIT] && pwdata[START_BIT] && enable_q
         && state_q != CONVERT)
        |-> ##[1:3] (state_q == CONVERT))
        else $error("start did not begin a conversion");

    // The flag may never read as done while the sequencer converts
    flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == CONVERT) |-> !done_q)
        else $error("process flag set during conversion");

    // Completion is the only way the flag rises
    flag_done_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(done_q)) |-> ($past(state_q) == CONVERT && state_q == DONE_ST))
        else $error("process flag rose without completion");

    // Turning the converter off abandons any conversion and clears the flag
    disabled_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!enable_q) |=> (state_q == IDLE && !done_q))
        else $error("conversion while disabled");

    // Result words only move at completion
    result_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q != CONVERT) |=> $stable(result_q))
        else $error("result changed outside completion");

    // Reference code switches the band-gap onto the core input
    bandgap_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        (chan_q == CHAN_BANDGAP) |=> conv_bandgap)
        else $error("band-gap not routed");

    // Divide by two: the tick comes back every second cycle while the code holds
    tick_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
        ((enable_q && div_q == 3'h1 && tick_q) ##1 (enable_q && div_q == 3'h1))
        |-> (!tick_q ##1 tick_q))
        else $error("divide by two rate wrong");

    // Low result word: data in the upper nibble, reserved nibble reads zero
    low_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_en && pready && paddr == RESL_ADDR) |-> (prdata[3:0] == 4'h0
         && prdata[7:4] == $past(result_q[3:0])))
        else $error("low result read wrong");

    // Enable bit follows every accepted control write
    enable_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == CTRL_ADDR) |=> (enable_q == $past(pwdata[ENABLE_BIT])))
        else $error("enable bit not stored");

    // Core enable mirrors the register bit one cycle later
    enable_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_enable == $past(enable_q))
        else $error("core enable does not follow register");

    // Divider stays parked while the converter is off, so no stray ticks
    divider_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!enable_q) |=> (!tick_q && divcnt_q == 7'h00))
        else $error("divider ran while disabled");

    // An enabled start write leaves a pending request behind
    start_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == CTRL_ADDR && pwdata[START_BIT] && pwdata[ENABLE_BIT]) |=> start_q)
        else $error("start request lost");

    // Taking a request starts the core and clears the process flag together
    start_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
        (enable_q && start_q && state_q != CONVERT) |=> (state_q == CONVERT && !done_q
         && conv_sample))
        else $error("start did not clear the flag");

    // Control read returns the flag and enable as they stood at setup
    flag_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_en && pready && paddr == CTRL_ADDR) |-> (prdata[START_BIT] == $past(done_q)
         && prdata[ENABLE_BIT] == $past(enable_q)))
        else $error("control read wrong");

    // Listed pin codes reach the core unchanged
    pin_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        (chan_q <= CHAN_MAX_PIN && chan_q != CHAN_RSVD) |=> (conv_channel == $past(chan_q)))
        else $error("channel not routed");

    // Reserved and reference codes select no pin, parking the input on zero
    reserved_chan_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!(chan_q <= CHAN_MAX_PIN && chan_q != CHAN_RSVD)) |=> (conv_channel == CHAN_RESET))
        else $error("reserved channel routed a pin");

    // Reference switch drops as soon as another code is chosen
    bandgap_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        (chan_q != CHAN_BANDGAP) |=> !conv_bandgap)
        else $error("band-gap left connected");

    // Mode fields move only on a write to their own word
    mode_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!(wr_en && paddr == MODE_ADDR)) |=> ($stable(res_q) && $stable(div_q)))
        else $error("mode fields changed without a write");

    // Write-only mode word reads back as zero
    mode_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_en && pready && paddr == MODE_ADDR) |-> (prdata == 32'h0000_0000))
        else $error("mode word not hidden");

    // High result word carries the top eight result bits, top bit in bit 7
    high_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_en && pready && paddr == RESH_ADDR) |-> (prdata[7:0] == $past(result_q[11:4])
         && prdata[31:8] == 24'h000000))
        else $error("high result read wrong");

    // Completion stores exactly what the core presents
    result_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
        (enable_q && state_q == CONVERT && tick_q && ticks_q == CONV_TICKS - 5'h01)
        |=> (result_q == $past(conv_data)))
        else $error("result not captured at completion");

    // Core clock pulses for every tick inside a conversion
    core_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick_q && state_q == CONVERT) |=> conv_clk_en)
        else $error("converter tick not passed on");

    // Without enable in force or in the same write, no request survives
    disabled_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!enable_q && !(wr_en && paddr == CTRL_ADDR && pwdata[ENABLE_BIT])) |=> !start_q)
        else $error("start kept while disabled");
endmodule

/* verilog/adc_ctrl_pkg.sv */
// How it works
// - Control bit 7 enables the converter; clear disables it; resets to zero.
// - Writing one to control bit 6 requests a conversion start.
// - Process flag clears by itself when the conversion really begins.
// - Process flag reads zero while converting, one once done.
// - Channel field bits 5..2 pick inputs 0..9; 0111 and unlisted codes reserved.
// - Channel code 1111 routes the internal band-gap reference to the converter.
// - Mode bits 7..5 select resolution; 100 is 12-bit; write-only, reset 000. The code stores them but always converts 12 bits.
// - Result is high register bits 7..0 above low register bits 7..4.
// - Mode bits 3..1 divide the system clock by 1 up to 128.
// - High result register is read-only and holds result bits 11..4.
// - High result bit 7 always carries the result's top bit.
// - Low result bits 7..4 hold result bits 3..0; bits 3..0 read zero.
package adc_ctrl_pkg;
    // Byte addresses of the register words
    localparam logic [7:0] CTRL_ADDR = 8'h80;
    localparam logic [7:0] MODE_ADDR = 8'h84;
    localparam logic [7:0] RESH_ADDR = 8'h88;
    localparam logic [7:0] RESL_ADDR = 8'h8C;
    // Printed register indices
    localparam logic [7:0] CTRL_INDEX = 8'h20;
    localparam logic [7:0] MODE_INDEX = 8'h21;
    localparam logic [7:0] RESH_INDEX = 8'h22;
    localparam logic [7:0] RESL_INDEX = 8'h23;
    // Field positions
    localparam int ENABLE_BIT = 7;
    localparam int START_BIT = 6;
    localparam int CHAN_LSB = 2;
    localparam int RES_LSB = 5;
    localparam int DIV_LSB = 1;
    // Values after reset and field codes
    localparam logic [3:0] CHAN_RESET = 4'h0;
    localparam logic [2:0] RES_RESET = 3'h0;
    localparam logic [2:0] DIV_RESET = 3'h0;
    localparam logic [2:0] RES_12BIT = 3'h4;
    localparam logic [3:0] CHAN_BANDGAP = 4'hF;
    localparam logic [3:0] CHAN_MAX_PIN = 4'h9;
    localparam logic [3:0] CHAN_RSVD = 4'h7;
    // Conversion length in converter clock ticks, one per result bit plus sampling
    localparam logic [4:0] CONV_TICKS = 5'h0E;
    localparam int RESULT_W = 12;
endpackage
